// ### rtl/brw_boot_ctl.sv
/*
 * boot rom width control, instruction fetch assembly and clock prescalers.
 * assumes the rom answers each read with rom_ack_i, one read at a time,
 * and that the cpu raises cpu_fetch_i again only after a word is returned.
 */
module brw_boot_ctl (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire brw_pkg::brw_reg_req_t reg_req_i,
  output logic [7:0]                 reg_rdata_o,
  input  wire logic                  cpu_fetch_i,
  input  wire logic [31:0]           cpu_addr_i,
  output brw_pkg::brw_fetch_t        fetch_o,
  output brw_pkg::brw_rom_req_t      rom_req_o,
  input  wire logic                  rom_ack_i,
  input  wire logic [31:0]           rom_data_i,
  input  wire logic                  cpu_clock_input_i,
  input  wire logic                  memory_clock_input_i,
  input  wire logic                  io_clock_input_i,
  output logic                       cpu_clk_o,
  output logic                       mem_clk_o,
  output logic                       io_clk_o,
  output logic                       rom_wide_o
);
  import brw_pkg::*;

  typedef enum {ST_BOOT, ST_IDLE, ST_LO, ST_HI, ST_WORD} brw_state_t;

  brw_state_t            state;
  brw_state_t            next_state;
  logic [7:0]            rom_bank0_control;
  logic [7:0]            next_rom_bank0_control;
  logic [7:0]            clock_divider_control;
  logic [7:0]            next_clock_divider_control;
  logic [7:0]            rdata;
  logic [7:0]            next_rdata;
  logic [15:0]           low_half;
  logic [15:0]           next_low_half;
  logic [31:0]           fetch_addr;
  logic [31:0]           next_fetch_addr;
  brw_rom_req_t          rom_req;
  brw_rom_req_t          next_rom_req;
  brw_fetch_t            fetch;
  brw_fetch_t            next_fetch;
  logic                  narrow;

  assign narrow = rom_bank0_control[ROM_WIDTH_BIT];

  // register file; writes to unmapped offsets are dropped
  always_comb begin
    next_rom_bank0_control     = rom_bank0_control;
    next_clock_divider_control = clock_divider_control;
    if (reg_req_i.wr) begin
      case (reg_req_i.offset)
        ROM_BANK0_CTL_OFS: next_rom_bank0_control = reg_req_i.wdata;
        CLK_DIV_CTL_OFS:   next_clock_divider_control = reg_req_i.wdata;
        default:           next_rom_bank0_control = rom_bank0_control;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rom_bank0_control     <= ROM_CTL_RESET;
      clock_divider_control <= CLK_CTL_RESET;
    end else begin
      rom_bank0_control     <= next_rom_bank0_control;
      clock_divider_control <= next_clock_divider_control;
    end
  end

  // read port; a read beside a write in one cycle returns the old value
  always_comb begin
    next_rdata = rdata;
    if (reg_req_i.rd) begin
      case (reg_req_i.offset)
        ROM_BANK0_CTL_OFS: next_rdata = rom_bank0_control;
        CLK_DIV_CTL_OFS:   next_rdata = clock_divider_control;
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // fetch sequencer; width is sampled only when a fetch starts, so a
  // width change mid-fetch cannot split one instruction across modes
  always_comb begin
    next_state      = state;
    next_low_half   = low_half;
    next_fetch_addr = fetch_addr;
    next_rom_req    = rom_req;
    next_fetch      = '{valid: 1'b0, data: fetch.data};
    case (state)
      ST_BOOT: begin
        if (cpu_fetch_i) begin
          // pairing spans two word slots, so a narrow fetch at word n
          // reads slots 2n and 2n+1 starting from physical zero
          next_fetch_addr   = BOOT_ADDR;
          next_rom_req.req  = 1'b1;
          next_rom_req.addr = BOOT_ADDR;
          next_state        = narrow ? ST_LO : ST_WORD;
        end
      end
      ST_IDLE: begin
        if (cpu_fetch_i) begin
          next_fetch_addr  = cpu_addr_i;
          next_rom_req.req = 1'b1;
          if (narrow) begin
            next_rom_req.addr = {cpu_addr_i[30:0], 1'b0};
            next_state        = ST_LO;
          end else begin
            next_rom_req.addr = cpu_addr_i;
            next_state        = ST_WORD;
          end
        end
      end
      ST_LO: begin
        if (rom_ack_i) begin
          next_low_half     = rom_data_i[15:0];
          // second half sits one word slot above the first
          next_rom_req.addr = {fetch_addr[30:0], 1'b0} + HALF_STEP;
          next_state        = ST_HI;
        end
      end
      ST_HI: begin
        if (rom_ack_i) begin
          next_rom_req.req = 1'b0;
          next_fetch.valid = 1'b1;
          next_fetch.data  = {rom_data_i[15:0], low_half};
          next_state       = ST_IDLE;
        end
      end
      ST_WORD: begin
        if (rom_ack_i) begin
          next_rom_req.req = 1'b0;
          next_fetch.valid = 1'b1;
          next_fetch.data  = rom_data_i;
          next_state       = ST_IDLE;
        end
      end
      default: begin
        // unreachable state: drop any rom read and restart from boot
        next_rom_req.req = 1'b0;
        next_state       = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state      <= ST_BOOT;
      low_half   <= 16'h0000;
      fetch_addr <= 32'h0000_0000;
      rom_req    <= '0;
      fetch      <= '0;
    end else begin
      state      <= next_state;
      low_half   <= next_low_half;
      fetch_addr <= next_fetch_addr;
      rom_req    <= next_rom_req;
      fetch      <= next_fetch;
    end
  end

  // rom_wide_o shows the register setting one cycle late, not the width
  // of a fetch that is already in flight
  logic wide_q;
  logic next_wide_q;
  always_comb begin
    next_wide_q = ~narrow;
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wide_q <= 1'b0;
    end else begin
      wide_q <= next_wide_q;
    end
  end

  // all three prescalers share one design; each has its own control bit
  brw_prescaler u_cpu_div (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .src_clk_i (cpu_clock_input_i),
    .div2_i    (clock_divider_control[DIV_CPU_BIT]),
    .clk_o     (cpu_clk_o)
  );

  brw_prescaler u_mem_div (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .src_clk_i (memory_clock_input_i),
    .div2_i    (clock_divider_control[DIV_MEM_BIT]),
    .clk_o     (mem_clk_o)
  );

  brw_prescaler u_io_div (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .src_clk_i (io_clock_input_i),
    .div2_i    (clock_divider_control[DIV_IO_BIT]),
    .clk_o     (io_clk_o)
  );

  assign reg_rdata_o = rdata;
  assign fetch_o     = fetch;
  assign rom_req_o   = rom_req;
  assign rom_wide_o  = wide_q;
endmodule // brw_boot_ctl

// ### include/brw_pkg.sv
/*
 * shared constants and carriers for the boot rom width / clock prescaler block.
 * assumes a single mclk_i domain; the cpu side issues one fetch at a time.
 */
package brw_pkg;
  localparam logic [31:0] REG_BASE          = 32'h0320_0000;
  localparam logic [7:0]  ROM_BANK0_CTL_OFS = 8'h80;
  localparam logic [7:0]  CLK_DIV_CTL_OFS   = 8'h84;
  localparam int          ROM_WIDTH_BIT     = 6;
  localparam logic [7:0]  ROM_CTL_RESET     = 8'h40;
  localparam int          DIV_CPU_BIT       = 0;
  localparam int          DIV_MEM_BIT       = 1;
  localparam int          DIV_IO_BIT        = 2;
  localparam logic [7:0]  CLK_CTL_RESET     = 8'h07;
  localparam logic [31:0] BOOT_ADDR         = 32'h0000_0000;
  localparam logic [31:0] HALF_STEP         = 32'h0000_0004;
  localparam logic [31:0] WORD_STEP         = 32'h0000_0004;
  localparam logic [31:0] PAIR_STEP         = 32'h0000_0008;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } brw_rom_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } brw_fetch_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  offset;
    logic [7:0]  wdata;
  } brw_reg_req_t;
endpackage

// ### rtl/brw_prescaler.sv
/*
 * one clock prescaler: divides its input clock by 1 or 2.
 * assumes the source clock is sampled as a synchronous input of mclk_i
 * and that mclk_i runs at least twice the source rate.
 */
module brw_prescaler (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic src_clk_i,
  input  wire logic div2_i,
  output logic      clk_o
);
  import brw_pkg::*;

  logic src_q;
  logic next_src_q;
  logic half;
  logic next_half;
  logic mode2;
  logic next_mode2;
  logic out_q;
  logic next_out_q;
  logic rise;

  always_comb begin
    rise       = src_clk_i & ~src_q;
    next_src_q = src_clk_i;
    next_half  = half;
    next_mode2 = mode2;
    next_out_q = out_q;
    if (rise) begin
      next_half = ~half;
    end
    // mode changes only while the output is low and the divider is at
    // phase zero, so no shortened high or low phase can appear
    if (!out_q && !half && !src_clk_i) begin
      next_mode2 = div2_i;
    end
    if (mode2) begin
      if (rise) begin
        next_out_q = ~half;
      end
    end else begin
      next_out_q = src_clk_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      src_q <= 1'b0;
      half  <= 1'b0;
      mode2 <= 1'b1;
      out_q <= 1'b0;
    end else begin
      src_q <= next_src_q;
      half  <= next_half;
      mode2 <= next_mode2;
      out_q <= next_out_q;
    end
  end

  assign clk_o = out_q;
endmodule // brw_prescaler

// ### sim/brw_rom_model.sv
/* boot rom bank model, one read per ack.
   assumes a registered request held until its ack. */
module brw_rom_model (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [1:0]            slow_i,
  input  wire brw_pkg::brw_rom_req_t rom_req_i,
  output logic                       rom_ack_o,
  output logic [31:0]                rom_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import brw_pkg::*;
  logic [1:0]  cnt;
  logic [31:0] word;
  // upper half differs so a kept upper half is seen
  assign word = {~rom_req_i.addr[15:0], rom_req_i.addr[15:0]};
  // between acks the bus shows the inverse, never a stale match
  assign rom_data_o = rom_ack_o ? word : ~word;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || rom_ack_o || !rom_req_i.req) begin
      rom_ack_o <= 1'b0;
      cnt <= 2'h0;
    end else if (cnt == slow_i) begin
      rom_ack_o <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule // brw_rom_model

// ### sim/brw_boot_ctl_checker.sv
/* port checker for the boot width block.
   assumes one mclk_i domain and sync reset. */
module brw_boot_ctl_checker (
  input wire logic                  mclk_i,
  input wire logic                  rst_n_i,
  input wire logic                  cpu_fetch_i,
  input wire brw_pkg::brw_fetch_t   fetch_o,
  input wire brw_pkg::brw_rom_req_t rom_req_o,
  input wire logic                  rom_ack_i,
  input wire logic [31:0]           rom_data_i,
  input wire logic                  cpu_clk_o,
  input wire logic                  io_clk_o,
  input wire logic                  rom_wide_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  chk_boot_narrow: assert property ($rose(rst_n_i) |-> !rom_wide_o)
    else $error("wide after reset");
  chk_req_cause: assert property ($rose(rom_req_o.req) |->
    $past(cpu_fetch_i)) else $error("rom read without fetch");
  chk_req_hold: assert property (rom_req_o.req && !rom_ack_i |=>
    rom_req_o.req && $stable(rom_req_o.addr)) else $error("req dropped");
  chk_narrow_step: assert property (rom_req_o.req && rom_ack_i
    && !rom_wide_o && !rom_req_o.addr[2] |=>
    rom_req_o.addr == $past(rom_req_o.addr) + 32'h4)
    else $error("second half address");
  chk_upper_drop: assert property (fetch_o.valid && !rom_wide_o |->
    fetch_o.data[31:16] == 16'($past(rom_data_i))) else $error("upper half");
  chk_valid_ack: assert property (fetch_o.valid |-> $past(rom_ack_i))
    else $error("valid without ack");
  chk_io_rise: assert property ($rose(io_clk_o) |=> io_clk_o)
    else $error("runt high");
  chk_cpu_fall: assert property ($fell(cpu_clk_o) |=> !cpu_clk_o)
    else $error("runt low");
  chk_io_high: assert property ($rose(io_clk_o) |-> ##[1:4] !io_clk_o)
    else $error("io high too long");
endmodule // brw_boot_ctl_checker
bind brw_boot_ctl brw_boot_ctl_checker i_chk (.mclk_i, .rst_n_i, .cpu_fetch_i,
  .fetch_o, .rom_req_o, .rom_ack_i, .rom_data_i, .cpu_clk_o, .io_clk_o,
  .rom_wide_o);

// ### sim/tb_top.sv
/* testbench: register, fetch and prescaler sequences.
   assumes all source clocks at a quarter of mclk_i. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import brw_pkg::*;
  logic mclk_i = 0, rst_n_i = 0, cpu_fetch_i = 0, src = 0, rom_ack_i;
  logic cpu_clk_o, mem_clk_o, io_clk_o, rom_wide_o;
  logic [1:0] slow = 0, ph = 0;
  logic [7:0] reg_rdata_o;
  logic [31:0] cpu_addr_i = 0, rom_data_i;
  brw_reg_req_t reg_req_i = '0;
  brw_fetch_t fetch_o;
  brw_rom_req_t rom_req_o;
  int errors = 0, comparisons = 0, cyc = 0, nc, nm, ni;
  brw_boot_ctl i_dut (.mclk_i, .rst_n_i, .reg_req_i, .reg_rdata_o,
    .cpu_fetch_i, .cpu_addr_i, .fetch_o, .rom_req_o, .rom_ack_i, .rom_data_i,
    .cpu_clock_input_i(src), .memory_clock_input_i(src),
    .io_clock_input_i(src), .cpu_clk_o, .mem_clk_o, .io_clk_o, .rom_wide_o);
  brw_rom_model i_rom (.mclk_i, .rst_n_i, .slow_i(slow),
    .rom_req_i(rom_req_o), .rom_ack_o(rom_ack_i), .rom_data_o(rom_data_i));
  initial forever #12.5 mclk_i = ~mclk_i;
  always @(posedge cpu_clk_o) nc++;
  always @(posedge mem_clk_o) nm++;
  always @(posedge io_clk_o) ni++;
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // whole run needs a few hundred cycles
  always @(posedge mclk_i) begin
    ph <= ph + 2'h1;
    src <= ph[1];
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic reg_wr(input logic [7:0] o, d);
    @(posedge mclk_i) reg_req_i <= '{1'b1, 1'b0, o, d};
    @(posedge mclk_i) reg_req_i <= '0;
  endtask
  task automatic reg_rd(input logic [7:0] o, e);
    @(posedge mclk_i) reg_req_i <= '{1'b0, 1'b1, o, 8'h00};
    @(posedge mclk_i) reg_req_i <= '0;
    #1 chk({24'h0, reg_rdata_o}, {24'h0, e});
  endtask
  task automatic fetch(input logic [31:0] a, e);
    int i;
    @(posedge mclk_i) cpu_fetch_i <= 1'b1;
    cpu_addr_i <= a;
    @(posedge mclk_i) cpu_fetch_i <= 1'b0;
    #1;
    for (i = 0; i < 40 && fetch_o.valid !== 1'b1; i++) begin
      @(posedge mclk_i);
      #1;
    end
    chk(fetch_o.data, e);
  endtask
  function automatic logic [31:0] nw(input logic [31:0] c);
    logic [15:0] a;
    a = 16'(c << 1);
    return {a + 16'h0004, a};
  endfunction
  task automatic count(input int e);
    #1 nc = 0;
    nm = 0;
    ni = 0;
    repeat (64) @(posedge mclk_i);
    #1;
    chk(nc, e);
    chk(nm, e);
    chk(ni, e);
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    reg_rd(8'h80, 8'h40);
    reg_rd(8'h84, 8'h07);
    reg_rd(8'h10, 8'h00);
    fetch(32'h0, nw(32'h0));
    fetch(32'h10, nw(32'h10));
    slow = 2'h2;
    fork
      fetch(32'h20, nw(32'h20));
      begin
        repeat (2) @(posedge mclk_i);
        reg_wr(8'h80, 8'h00);
      end
    join
    reg_rd(8'h80, 8'h00);
    chk({31'h0, rom_wide_o}, 32'h1);
    fetch(32'h30, {~16'h0030, 16'h0030});
    count(8);
    reg_wr(8'h84, 8'h00);
    repeat (16) @(posedge mclk_i);
    count(16);
    tally_and_finish();
  end
endmodule // tb_top
